/* File: umh_pkg.sv */
`default_nettype none
package umh_pkg;
  // ==========================================
  // Bus shape
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ==========================================
  // Register indices (three address bits)
  localparam logic [2:0] REG_DATA = 3'h0; // Read: receive byte, write: transmit hold
  localparam logic [2:0] REG_IEN = 3'h1; // interrupt_enable_reg
  localparam logic [2:0] REG_EFR = 3'h2; // enhanced_feature_reg
  localparam logic [2:0] REG_IID = 3'h3; // Interrupt identity, read only
  localparam logic [2:0] REG_MCR = 3'h4; // modem_control_reg
  localparam logic [2:0] REG_LSR = 3'h5; // Line status, read only
  localparam logic [2:0] REG_MSR = 3'h6; // modem_status_reg, read only
  localparam logic [2:0] REG_XCR = 3'h7; // Extra control

  // ==========================================
  // Field positions
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRQEN = 3;
  localparam int MCR_LOOP = 4;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int XCR_RS485 = 0;
  localparam int LSR_DR = 0;
  localparam int LSR_ERR = 1;
  localparam int LSR_THRE = 5;
  localparam int IEN_W = 4; // rx avail, thr empty, line error, modem
  localparam int MODEM_W = 4; // cts, dsr, ri, cd
  localparam int MSR_RI = 2;

  // ==========================================
  // Reset values and identity codes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [7:0] IID_NONE = 8'h01;
  localparam logic [7:0] IID_LINE = 8'h06;
  localparam logic [7:0] IID_RXAV = 8'h04;
  localparam logic [7:0] IID_THRE = 8'h02;
  localparam logic [7:0] IID_MODEM = 8'h00;

  // ==========================================
  // Host strobe timing
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SETUP = 2'b01,
    HST_STROBE = 2'b10,
    HST_HOLD = 2'b11
  } umh_hstate_e;
endpackage
`default_nettype wire

/* File: umh_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface umh_bus_if import umh_pkg::*; ();
  // ==========================================
  // Parallel host bus, data split into two driven halves
  logic selN;
  logic rdN;
  logic wrN;
  logic resetPin;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [DATA_W-1:0] devData;
  logic devDataOe;

  modport dev (
    input selN, rdN, wrN, resetPin, addr, hostData, hostDataOe,
    output devData, devDataOe
  );
  modport host (
    output selN, rdN, wrN, resetPin, addr, hostData, hostDataOe,
    input devData, devDataOe
  );
endinterface
`default_nettype wire

/* File: umh_host.sv */
`timescale 1ns/10ps
`default_nettype none
module umh_host import umh_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus to the device
  umh_bus_if.host bus,
  // User command port
  input wire logic chipReset,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData
);
  // ==========================================
  // Sequencer state
  umh_hstate_e state_q;
  umh_hstate_e state_d;
  logic [3:0] cnt_q;
  logic isWrite_q;

  // Command is taken only from idle with ready shown
  wire take = cmdValid & cmdReady;
  wire strobeDone = (state_q == HST_STROBE) & (cnt_q == STROBE_LAST);

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HST_IDLE: if (take) state_d = HST_SETUP;
      HST_SETUP: state_d = HST_STROBE;
      HST_STROBE: if (strobeDone) state_d = HST_HOLD;
      HST_HOLD: state_d = HST_IDLE;
    endcase
  end

  // State, counter and select; chip select opens before and closes after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= HST_IDLE;
      cnt_q <= CNT_ZERO;
      bus.selN <= 1'b1;
      isWrite_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= (state_q == HST_STROBE) ? cnt_q + CNT_ONE : CNT_ZERO;
      if (take) begin
        bus.selN <= 1'b0;
        isWrite_q <= cmdWrite;
      end else if (state_q == HST_HOLD) begin
        bus.selN <= 1'b1;
      end
    end
  end

  // Strobes are held low for the whole strobe width
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.rdN <= 1'b1;
      bus.wrN <= 1'b1;
    end else if (ce) begin
      bus.rdN <= !((state_q == HST_SETUP & !isWrite_q) | (state_q == HST_STROBE &
                   !strobeDone & !isWrite_q));
      bus.wrN <= !((state_q == HST_SETUP & isWrite_q) | (state_q == HST_STROBE &
                   !strobeDone & isWrite_q));
    end
  end

  // Address and write data stay put from take to end of hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.addr <= '0;
      bus.hostData <= REG_RST;
      bus.hostDataOe <= 1'b0;
      bus.resetPin <= 1'b0;
    end else if (ce) begin
      bus.resetPin <= chipReset;
      if (take) begin
        bus.addr <= cmdAddr;
        bus.hostData <= cmdData;
        bus.hostDataOe <= cmdWrite;
      end else if (state_q == HST_HOLD) begin
        bus.hostDataOe <= 1'b0;
      end
    end
  end

  // Answer: read data caught at the last strobe cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdReady <= 1'b1;
      rspValid <= 1'b0;
      rspData <= REG_RST;
    end else if (ce) begin
      cmdReady <= take ? 1'b0 : (state_q == HST_HOLD) ? 1'b1 : cmdReady;
      rspValid <= state_q == HST_HOLD;
      if (strobeDone & !isWrite_q) begin
        rspData <= bus.devData;
      end
    end
  end
endmodule
`default_nettype wire

/* File: umh_device.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - MODEM_CONTROL_REG bit 0 set drives terminal-ready low
// - Terminal-ready high after reset
// - RS-485 mode: terminal-ready is driver direction
// - IRQ needs bit 3, enable and condition
// - Sources: errors, rx data, thr empty, modem
// - IRQ output tri-stated after reset
// - Read strobe low drives selected register out
// - Write strobe low loads selected register
// - Bit 3 drives IRQ, user output low
// - User output high after reset
// - Reset pin clears registers and outputs
// - Serial tx and rx disabled during reset
// - Ring rising edge raises modem interrupt
// - Ring level readable in modem status
// - MODEM_CONTROL_REG bit 1 drives request-to-send low
// - Request-to-send high after reset
// - Auto RTS flow only with ENHANCED_FEATURE_REG bit 6
// - Loopback ignores rx pin, feeds tx back
// - Line driver holds rx high when idle
// - Modem drives data-set-ready low when ready
// - CTS gates tx only with ENHANCED_FEATURE_REG bit 7
// - Only a selected channel answers strobes
module umh_device import umh_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus from the host
  umh_bus_if.dev bus,
  // Modem and serial pins, active low where named so
  input wire logic ctsN,
  input wire logic dsrN,
  input wire logic riN,
  input wire logic cdN,
  input wire logic serial_rx_in,
  output logic serialTxOut,
  output logic dtrN,
  output logic rtsN,
  output logic user_output_n,
  output logic channel_irq_out,
  output logic channelIrqOe,
  // Transmitter and receiver side of the channel
  input wire logic txSerial,
  input wire logic txBusy,
  input wire logic txTake,
  input wire logic rxAvail,
  input wire logic rxRoom,
  input wire logic rxErr,
  input wire logic [DATA_W-1:0] rxByte,
  output logic rxLine,
  output logic txAllowed,
  output logic txHoldFull,
  output logic [DATA_W-1:0] txHoldByte
);
  // ==========================================
  // Pin synchronisers: {rx, cd, ri, dsr, cts}
  logic [MODEM_W:0] pinMeta_q;
  logic [MODEM_W:0] pinSync_q;

  // Pins come from outside the clock domain, two flops first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= '1;
      pinSync_q <= '1;
    end else if (ce) begin
      pinMeta_q <= {serial_rx_in, cdN, riN, dsrN, ctsN};
      pinSync_q <= pinMeta_q;
    end
  end

  // Active-high modem levels, bit order cts, dsr, ri, cd
  wire [MODEM_W-1:0] modemNow = ~pinSync_q[MODEM_W-1:0];
  wire rxPin = pinSync_q[MODEM_W];

  // ==========================================
  // Bus decode
  logic rdPrev_q;
  logic wrPrev_q;

  // Strobes count only while this channel is selected
  wire selected = !bus.selN;
  wire rdNow = selected & !bus.rdN;
  wire wrNow = selected & !bus.wrN;
  wire rdStart = rdNow & !rdPrev_q;
  wire wrStart = wrNow & !wrPrev_q;
  wire chipRst = bus.resetPin;

  // One decoder for both access kinds, used for every register a strobe acts on
  function automatic logic hit(input logic start, input logic [2:0] a,
                               input logic [2:0] idx);
    hit = start & (a == idx);
  endfunction

  wire wrThr = hit(wrStart, bus.addr, REG_DATA);
  wire wrIen = hit(wrStart, bus.addr, REG_IEN);
  wire wrEfr = hit(wrStart, bus.addr, REG_EFR);
  wire wrMcr = hit(wrStart, bus.addr, REG_MCR);
  wire wrXcr = hit(wrStart, bus.addr, REG_XCR);
  wire rdLsr = hit(rdStart, bus.addr, REG_LSR);
  wire rdMsr = hit(rdStart, bus.addr, REG_MSR);

  // Edge history so a long strobe acts only once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPrev_q <= 1'b0;
      wrPrev_q <= 1'b0;
    end else if (ce) begin
      rdPrev_q <= rdNow;
      wrPrev_q <= wrNow;
    end
  end

  // ==========================================
  // Software registers
  logic [IEN_W-1:0] ien_q;
  logic [DATA_W-1:0] efr_q;
  logic [DATA_W-1:0] mcr_q;
  logic [DATA_W-1:0] xcr_q;
  logic [DATA_W-1:0] thr_q;

  // Reset pin returns every register to its reset value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ien_q <= NIBBLE_RST;
      efr_q <= REG_RST;
      mcr_q <= REG_RST;
      xcr_q <= REG_RST;
      thr_q <= REG_RST;
    end else if (ce) begin
      if (chipRst) begin
        ien_q <= NIBBLE_RST;
        efr_q <= REG_RST;
        mcr_q <= REG_RST;
        xcr_q <= REG_RST;
        thr_q <= REG_RST;
      end else begin
        if (wrIen) ien_q <= bus.hostData[IEN_W-1:0];
        if (wrEfr) efr_q <= bus.hostData;
        if (wrMcr) mcr_q <= bus.hostData;
        if (wrXcr) xcr_q <= bus.hostData;
        if (wrThr) thr_q <= bus.hostData;
      end
    end
  end

  // ==========================================
  // Event flags
  logic [MODEM_W-1:0] modemPrev_q;
  logic [MODEM_W-1:0] msrDelta_q;
  logic lsrErr_q;
  logic thrFull_q;

  // Any level change flags a delta; ring only on pin low-to-high
  wire [MODEM_W-1:0] modemChg = modemNow ^ modemPrev_q;
  wire riRise = modemPrev_q[MSR_RI] & !modemNow[MSR_RI];
  wire [MODEM_W-1:0] msrSet = {modemChg[3], riRise, modemChg[1:0]};

  // Hardware set beats a clear in the same cycle, so no event is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modemPrev_q <= NIBBLE_RST;
      msrDelta_q <= NIBBLE_RST;
      lsrErr_q <= 1'b0;
      thrFull_q <= 1'b0;
    end else if (ce) begin
      modemPrev_q <= modemNow;
      if (chipRst) begin
        msrDelta_q <= NIBBLE_RST;
        lsrErr_q <= 1'b0;
        thrFull_q <= 1'b0;
      end else begin
        msrDelta_q <= (msrDelta_q & ~{MODEM_W{rdMsr}}) | msrSet;
        lsrErr_q <= (lsrErr_q & !rdLsr) | rxErr;
        thrFull_q <= (thrFull_q | wrThr) & !txTake;
      end
    end
  end

  // ==========================================
  // Interrupt and read-back views
  wire [IEN_W-1:0] srcVec = {|msrDelta_q, lsrErr_q, !thrFull_q, rxAvail};
  wire [IEN_W-1:0] srcOn = srcVec & ien_q;
  wire irqCond = |srcOn;
  wire irqEn = mcr_q[MCR_IRQEN];

  // Highest pending source wins: line error, rx data, thr empty, modem
  wire [DATA_W-1:0] iidView = srcOn[2] ? IID_LINE :
                              srcOn[0] ? IID_RXAV :
                              srcOn[1] ? IID_THRE :
                              srcOn[3] ? IID_MODEM : IID_NONE;
  wire [DATA_W-1:0] msrView = {modemNow, msrDelta_q};
  logic [DATA_W-1:0] lsrView;
  logic [DATA_W-1:0] regView [8];

  // Line status bits gathered; unused bits read as zero
  always_comb begin
    lsrView = REG_RST;
    lsrView[LSR_DR] = rxAvail;
    lsrView[LSR_ERR] = lsrErr_q;
    lsrView[LSR_THRE] = !thrFull_q;
  end

  // Read map indexed by the three address bits
  assign regView[REG_DATA] = rxByte;
  assign regView[REG_IEN] = {{(DATA_W-IEN_W){1'b0}}, ien_q};
  assign regView[REG_EFR] = efr_q;
  assign regView[REG_IID] = iidView;
  assign regView[REG_MCR] = mcr_q;
  assign regView[REG_LSR] = lsrView;
  assign regView[REG_MSR] = msrView;
  assign regView[REG_XCR] = xcr_q;
  wire [DATA_W-1:0] readVal = regView[bus.addr];

  // ==========================================
  // Pin drive decisions
  wire loopOn = mcr_q[MCR_LOOP];
  wire autoRts = efr_q[EFR_ARTS];
  wire rs485On = xcr_q[XCR_RS485];

  // RS-485 turns terminal-ready into the driver enable while sending
  wire dtrLow = rs485On ? txBusy : mcr_q[MCR_DTR];
  // Auto RTS also drops the request when the receiver has no room
  wire rtsLow = mcr_q[MCR_RTS] & (!autoRts | rxRoom);
  wire ctsOk = !efr_q[EFR_ACTS] | modemNow[0];
  // Idle line assumed high on the pin when nothing is received
  wire rxPick = loopOn ? txSerial : rxPin;

  // Value caught once at strobe start: read-to-clear flags must not vanish mid-read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.devData <= REG_RST;
      bus.devDataOe <= 1'b0;
    end else if (ce) begin
      bus.devDataOe <= rdNow & !chipRst;
      if (rdStart) bus.devData <= readVal;
    end
  end

  // Modem and interrupt pins, all from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dtrN <= 1'b1;
      rtsN <= 1'b1;
      user_output_n <= 1'b1;
      channel_irq_out <= 1'b0;
      channelIrqOe <= 1'b0;
    end else if (ce) begin
      dtrN <= chipRst | !dtrLow;
      rtsN <= chipRst | !rtsLow;
      user_output_n <= chipRst | !irqEn;
      channel_irq_out <= !chipRst & irqEn & irqCond;
      channelIrqOe <= !chipRst & irqEn;
    end
  end

  // Serial path; reset parks both lines at the idle mark
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serialTxOut <= 1'b1;
      rxLine <= 1'b1;
      txAllowed <= 1'b0;
      txHoldFull <= 1'b0;
      txHoldByte <= REG_RST;
    end else if (ce) begin
      serialTxOut <= chipRst | loopOn | txSerial;
      rxLine <= chipRst | rxPick;
      txAllowed <= !chipRst & ctsOk;
      txHoldFull <= thrFull_q;
      txHoldByte <= thr_q;
    end
  end
endmodule
`default_nettype wire

/* File: umh_bus_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host bus and channel pin properties
module umh_bus_properties import umh_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host bus
  input wire logic selN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic resetPin,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] hostData,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  // Channel pins
  input wire logic dtrN,
  input wire logic rtsN,
  input wire logic user_output_n,
  input wire logic channel_irq_out,
  input wire logic channelIrqOe,
  input wire logic serialTxOut,
  input wire logic rxLine
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Read answer and release, one cycle each way
  read_answer_a:
    assert property (!selN && !resetPin && $fell(rdN) |=> devDataOe)
      else $error("read strobe not answered");
  read_release_a:
    assert property (devDataOe && (rdN || selN) |=> !devDataOe)
      else $error("data bus not released");
  select_only_a:
    assert property ($rose(devDataOe) |-> !$past(selN) && !$past(rdN))
      else $error("device drove bus unselected");
  strobe_framed_a:
    assert property (!wrN || !rdN |-> !selN)
      else $error("strobe outside select");
  // Two drivers on one data wire would fight
  no_contention_a:
    assert property (!(devDataOe && hostDataOe))
      else $error("both ends drive data");
  write_stable_a:
    assert property (!wrN |-> hostDataOe && $stable(hostData) && $stable(addr))
      else $error("write data moved under strobe");
  write_width_a:
    assert property ($fell(wrN) |-> !wrN [*4] ##1 wrN)
      else $error("write strobe width wrong");
  // Interrupt drive and user output move together
  irq_mode_a:
    assert property (channelIrqOe != user_output_n)
      else $error("irq drive and user output disagree");
  irq_gated_a:
    assert property (channel_irq_out |-> channelIrqOe)
      else $error("irq high while tri-stated");
  chip_reset_a:
    assert property (resetPin && $past(resetPin) |=> dtrN && rtsN && user_output_n
      && !channelIrqOe && serialTxOut && rxLine)
      else $error("outputs not at reset values");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top import umh_pkg::*;;
  logic clk, rst_b, ce, chipReset, cmdValid, cmdWrite, cmdReady, rspValid;
  logic [2:0] cmdAddr;
  logic [7:0] cmdData, rspData, rxByte, txHoldByte;
  logic ctsN, dsrN, riN, cdN, rxIn, txSerial, txBusy, txTake, rxAvail, rxRoom, rxErr;
  logic serialTxOut, dtrN, rtsN, userOutN, irqOut, irqOe, rxLine, txAllowed, txHoldFull;
  int nFail, checks, cyc;

  // ==========================================
  // Both ends joined by one bus
  umh_bus_if bus();
  umh_host umh_host_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .bus(bus),
    .chipReset(chipReset), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
  umh_device umh_device_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .bus(bus), .ctsN(ctsN),
    .dsrN(dsrN), .riN(riN), .cdN(cdN), .serial_rx_in(rxIn), .serialTxOut(serialTxOut),
    .dtrN(dtrN), .rtsN(rtsN), .user_output_n(userOutN), .channel_irq_out(irqOut),
    .channelIrqOe(irqOe), .txSerial(txSerial), .txBusy(txBusy), .txTake(txTake),
    .rxAvail(rxAvail), .rxRoom(rxRoom), .rxErr(rxErr), .rxByte(rxByte), .rxLine(rxLine),
    .txAllowed(txAllowed), .txHoldFull(txHoldFull), .txHoldByte(txHoldByte));
  umh_bus_properties umh_bus_properties_inst (.clk(clk), .rst_b(rst_b), .selN(bus.selN),
    .rdN(bus.rdN), .wrN(bus.wrN), .resetPin(bus.resetPin), .addr(bus.addr),
    .hostData(bus.hostData), .hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe),
    .dtrN(dtrN), .rtsN(rtsN), .user_output_n(userOutN), .channel_irq_out(irqOut),
    .channelIrqOe(irqOe), .serialTxOut(serialTxOut), .rxLine(rxLine));

  // ==========================================
  // Clock and hang guard, about three times the expected run of some 295 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      nFail++;
      conclude();
    end
  end

  // ==========================================
  // Tasks; every step leaves time 1 ns after an edge
  task automatic conclude();
    if (nFail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  // One command, held until the edge that takes it, then a bounded wait
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdData = d;
    tick(1);
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    cmp1(rspValid, 1'b1);
    tick(2);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
    acc(1'b0, a, 8'h00);
    cmp8(rspData & mask, exp);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    {rst_b, chipReset, cmdValid, cmdWrite, txBusy, txTake, rxAvail, rxErr} = '0;
    {nFail, checks, cyc} = '0;
    ce = 1'b1;
    cmdAddr = 3'h0;
    {cmdData, rxByte} = {8'h00, 8'h5A};
    {ctsN, riN, cdN, txSerial, rxRoom} = '1;
    rxIn = 1'b1;
    dsrN = 1'b0;
    tick(2);
    rst_b = 1'b1;
    cmp1(dtrN, 1'b1);
    cmp1(rtsN, 1'b1);
    cmp1(userOutN, 1'b1);
    cmp1(irqOe, 1'b0);
    rd(REG_MCR, 8'h00, 8'hFF);
    rd(REG_DATA, 8'h5A, 8'hFF);
    wr(REG_MCR, 8'h03);
    cmp1(dtrN, 1'b0);
    cmp1(rtsN, 1'b0);
    rd(REG_MCR, 8'h03, 8'hFF);
    wr(REG_MCR, 8'h08);
    cmp1(dtrN, 1'b1);
    cmp1(userOutN, 1'b0);
    cmp1(irqOe, 1'b1);
    wr(REG_IID, 8'hA5);
    rd(REG_IID, IID_NONE, 8'hFF);
    // Each source alone: rx data enabled then masked, line error cleared by a read, thr empty after a take
    rxAvail = 1'b1;
    wr(REG_IEN, 8'h01);
    cmp1(irqOut, 1'b1);
    rd(REG_IID, IID_RXAV, 8'hFF);
    wr(REG_IEN, 8'h00);
    cmp1(irqOut, 1'b0);
    rxAvail = 1'b0;
    rxErr = 1'b1;
    tick(1);
    rxErr = 1'b0;
    wr(REG_IEN, 8'h04);
    rd(REG_IID, IID_LINE, 8'hFF);
    rd(REG_LSR, 8'h02, 8'h02);
    cmp1(irqOut, 1'b0);
    wr(REG_DATA, 8'h3C);
    cmp8(txHoldByte, 8'h3C);
    cmp1(txHoldFull, 1'b1);
    wr(REG_IEN, 8'h02);
    cmp1(irqOut, 1'b0);
    txTake = 1'b1;
    tick(1);
    txTake = 1'b0;
    tick(2);
    cmp1(txHoldFull, 1'b0);
    rd(REG_IID, IID_THRE, 8'hFF);
    // Ring: level while low, delta on the trailing edge
    wr(REG_IEN, 8'h08);
    {riN, ctsN} = 2'b00;
    tick(4);
    rd(REG_MSR, 8'h50, 8'h50);
    riN = 1'b1;
    tick(4);
    cmp1(irqOut, 1'b1);
    rd(REG_MSR, 8'h04, 8'h44);
    cmp1(irqOut, 1'b0);
    wr(REG_MCR, 8'h00);
    cmp1(irqOe, 1'b0);
    // Flow control only where enabled
    cmp1(txAllowed, 1'b1);
    ctsN = 1'b1;
    wr(REG_EFR, 8'h80);
    cmp1(txAllowed, 1'b0);
    wr(REG_MCR, 8'h02);
    rxRoom = 1'b0;
    tick(3);
    cmp1(rtsN, 1'b0);
    wr(REG_EFR, 8'h40);
    rd(REG_EFR, 8'h40, 8'hFF);
    cmp1(rtsN, 1'b1);
    rxRoom = 1'b1;
    tick(3);
    cmp1(rtsN, 1'b0);
    // Direction control while sending; a low enable must freeze the pin
    wr(REG_XCR, 8'h01);
    ce = 1'b0;
    txBusy = 1'b1;
    tick(3);
    cmp1(dtrN, 1'b1);
    ce = 1'b1;
    tick(3);
    cmp1(dtrN, 1'b0);
    txBusy = 1'b0;
    tick(3);
    cmp1(dtrN, 1'b1);
    // Receive line: pin in normal mode, own transmit in loopback
    rxIn = 1'b0;
    tick(4);
    cmp1(rxLine, 1'b0);
    wr(REG_MCR, 8'h1B);
    cmp1(rxLine, 1'b1);
    txSerial = 1'b0;
    tick(4);
    cmp1(rxLine, 1'b0);
    cmp1(serialTxOut, 1'b1);
    txSerial = 1'b1;
    // Chip reset in mid-run with outputs active
    chipReset = 1'b1;
    tick(4);
    cmp1(rtsN, 1'b1);
    cmp1(userOutN, 1'b1);
    cmp1(rxLine, 1'b1);
    cmp1(serialTxOut, 1'b1);
    chipReset = 1'b0;
    tick(2);
    rd(REG_MCR, 8'h00, 8'hFF);
    rd(REG_EFR, 8'h00, 8'hFF);
    conclude();
  end
endmodule
`default_nettype wire
